// file: sim/device_id_string_loader_tb_top.sv
/* Bench joining host and device ends over the link.
   Assumes design files and the link checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
module device_id_string_loader_tb_top;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ir_busy = 1'b0;
  logic       start = 1'b0;
  logic [4:0] len = 5'h00;
  logic [4:0] rd_addr = 5'h00;
  logic [7:0] str [0:31];
  logic [7:0] char_data;
  logic [4:0] char_idx;
  logic [4:0] id_len;
  logic [7:0] rd_data;
  logic       prog_mode;
  logic       link_allowed;
  logic       busy;
  logic       done;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  dil_link_if lnk_if ();
  dil_device i_dil_device (.sys_clk(sys_clk), .rst(rst), .lnk(lnk_if.dev),
    .ir_busy(ir_busy), .prog_mode(prog_mode), .link_allowed(link_allowed),
    .id_len(id_len), .rd_addr(rd_addr), .rd_data(rd_data));
  dil_host i_dil_host (.sys_clk(sys_clk), .rst(rst), .lnk(lnk_if.host),
    .start(start), .len(len), .char_data(char_data), .char_idx(char_idx),
    .busy(busy), .done(done));
  dil_link_properties i_dil_link_properties (.sys_clk(sys_clk), .rst(rst),
    .rst_dev_n(lnk_if.rst_dev_n), .dtr(lnk_if.dtr), .rts(lnk_if.rts),
    .cts_n(lnk_if.cts_n), .tx_valid(lnk_if.tx_valid),
    .tx_data(lnk_if.tx_data));
  // Clock and string source
  always #12.5 sys_clk = ~sys_clk;
  assign char_data = str[char_idx];
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  function automatic logic [7:0] exp_ch(input logic [7:0] c);
    exp_ch = (c >= 8'h20 && c <= 8'h7A) ? c : 8'h20;
  endfunction : exp_ch
  // Factory default character at a store index
  function automatic logic [7:0] def_ch(input int i);
    def_ch = dil_pkg::DEF_STR[8*(dil_pkg::MAX_LEN-1-i) +: 8];
  endfunction : def_ch
  // Full programming run, then wait for normal mode
  task automatic program_id(input logic [4:0] n);
    @(negedge sys_clk);
    len = n;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    chk("host busy", {7'h00, busy}, 8'h01);
    for (int k = 0; k < 200 && prog_mode !== 1'b1; k++)
      @(negedge sys_clk);
    chk("prog mode", {7'h00, prog_mode}, 8'h01);
    for (int k = 0; k < 2000 && !(done === 1'b1 && prog_mode === 1'b0); k++)
      @(negedge sys_clk);
    chk("mode", {7'h00, prog_mode}, 8'h00);
    chk("ready line", {7'h00, lnk_if.dtr}, 8'h00);
    chk("host done", {7'h00, done}, 8'h01);
    chk("host idle", {7'h00, busy}, 8'h00);
    chk("link", {7'h00, link_allowed}, 8'h01);
  endtask : program_id
  task automatic read_chk(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      rd_addr = i[4:0];
      @(negedge sys_clk);
      chk("char", rd_data, exp_ch(str[i]));
    end
  endtask : read_chk
  // Main sequence
  initial begin
    for (int i = 0; i < 32; i++) str[i] = 8'h61 + i[7:0];
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    repeat (30) @(negedge sys_clk);
    chk("mode", {7'h00, prog_mode}, 8'h00);
    chk("len", {3'h0, id_len}, 8'(dil_pkg::DEF_LEN));
    // Default string as preloaded
    for (int i = 0; i < dil_pkg::DEF_LEN; i++) begin
      @(negedge sys_clk);
      rd_addr = i[4:0];
      @(negedge sys_clk);
      chk("default", rd_data, def_ch(i));
    end
    ir_busy = 1'b1;
    @(negedge sys_clk);
    chk("busy", {7'h00, lnk_if.cts_n}, 8'h01);
    ir_busy = 1'b0;
    str[0] = 8'h20;
    str[1] = 8'h1F;
    str[2] = 8'h7A;
    str[3] = 8'h7B;
    program_id(5'h05);
    chk("len", {3'h0, id_len}, 8'h05);
    read_chk(5);
    for (int i = 0; i < 32; i++) str[i] = 8'h41 + i[7:0];
    program_id(5'h19);
    chk("len", {3'h0, id_len}, 8'h13);
    read_chk(19);
    program_id(5'h00);
    chk("len", {3'h0, id_len}, 8'h00);
    final_report();
  end
endmodule : device_id_string_loader_tb_top
`default_nettype wire

// file: sim/dil_link_properties.sv
/* Checker on the host-device link signals.
   Assumes one clock, instanced by the bench beside the link. */
`timescale 1ns/100ps
`default_nettype none
module dil_link_properties (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       rst_dev_n,
  input wire logic       dtr,
  input wire logic       rts,
  input wire logic       cts_n,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data
);
  logic [4:0] cnt_q;
  logic [7:0] len_q;
  logic       last;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Bytes sent since the device left reset
  always_ff @(posedge sys_clk) begin
    if (rst || !rst_dev_n) cnt_q <= 5'h00;
    else if (tx_valid) cnt_q <= cnt_q + 5'h01;
  end
  // Length byte as sent
  always_ff @(posedge sys_clk) begin
    if (tx_valid && cnt_q == 5'h00) len_q <= tx_data;
  end
  // Final byte of a transfer
  assign last = tx_valid && ((cnt_q == 5'h00) ? (tx_data == 8'h00)
                                              : ({3'h0, cnt_q} == len_q));
  sequence prog_rel_s;
    $rose(rst_dev_n) && dtr && !rts;
  endsequence
  sequence init_s;
    cts_n[*8];
  endsequence
  rel_lines_a: assert property ($rose(rst_dev_n) |-> dtr && !rts)
    else $error("device released without program lines");
  rst_hold_a: assert property ($fell(rst_dev_n) |-> !rst_dev_n[*8])
    else $error("device reset too short");
  init_wait_a: assert property (prog_rel_s |-> init_s)
    else $error("clear-to-send low during start-up");
  prog_ready_a: assert property (prog_rel_s |-> ##[16:40] !cts_n)
    else $error("program mode never ready");
  pace_a: assert property (tx_valid |-> ##[0:1] cts_n)
    else $error("clear-to-send not raised after byte");
  byte_gap_a: assert property (tx_valid |=> !tx_valid[*4])
    else $error("bytes too close");
  len_max_a: assert property (tx_valid && cnt_q == 5'h00 |-> tx_data <= 8'h13)
    else $error("length byte too large");
  char_rng_a: assert property (tx_valid && cnt_q != 5'h00 |->
                               tx_data >= 8'h20 && tx_data <= 8'h7A)
    else $error("character out of range");
  drop_dtr_a: assert property (last |-> ##[0:8] !dtr)
    else $error("ready line kept after last byte");
  idle_lines_a: assert property (!dtr |-> rts)
    else $error("lines left in program state");
  send_sel_a: assert property (tx_valid |-> dtr && rst_dev_n)
    else $error("byte sent outside programming");
endmodule : dil_link_properties
`default_nettype wire

// file: verilog/dil_device.sv
/*
  Device end: samples handshake lines after reset, receives length and
  characters through a two-entry buffer into a string store.
  Assumes the link interface and a host on the same sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dil_device (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  dil_link_if.dev         lnk,
  input  wire logic       ir_busy,
  output logic            prog_mode,
  output logic            link_allowed,
  output logic [4:0]      id_len,
  input  wire logic [4:0] rd_addr,
  output logic [7:0]      rd_data
);
  typedef enum logic [1:0] {
    ST_INIT = 2'b00, ST_LEN = 2'b01, ST_DATA = 2'b10, ST_NORM = 2'b11
  } dil_state_t;
  dil_state_t st_q;
  logic [7:0] mem_q [dil_pkg::MAX_LEN];
  logic [4:0] len_q, idx_q;
  logic [4:0] init_q;
  logic       dtr_s1_q, dtr_q, rts_s1_q, rts_q, rstn_s1_q, rstn_q;
  logic       v1_s1_q, v1_q;
  logic [7:0] d1_s1_q, d1_q;
  logic [7:0] buf_q [2];
  logic [1:0] cnt_q;
  logic       wr_q, rd_q;
  logic       pop;
  logic       in_rst;
  // Two-stage synchronisers on pin inputs
  always_ff @(posedge sys_clk) begin
    dtr_s1_q  <= lnk.dtr;
    dtr_q     <= dtr_s1_q;
    rts_s1_q  <= lnk.rts;
    rts_q     <= rts_s1_q;
    rstn_s1_q <= lnk.rst_dev_n;
    rstn_q    <= rstn_s1_q;
    v1_s1_q   <= lnk.tx_valid;
    v1_q      <= v1_s1_q;
    d1_s1_q   <= lnk.tx_data;
    d1_q      <= d1_s1_q;
  end
  assign in_rst = rst || !rstn_q;
  assign pop    = (cnt_q != 2'd0) && (st_q == ST_LEN || st_q == ST_DATA);
  // Two-entry receive buffer, drops a byte that arrives while both entries are full
  always_ff @(posedge sys_clk) begin
    if (in_rst) begin
      cnt_q <= 2'd0;
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
    end else begin
      if (v1_q && cnt_q != 2'd2) begin
        buf_q[wr_q] <= d1_q;
        wr_q        <= !wr_q;
      end
      if (pop)
        rd_q <= !rd_q;
      cnt_q <= cnt_q + {1'b0, (v1_q && cnt_q != 2'd2)} - {1'b0, pop};
    end
  end
  // Mode selection and string reception
  always_ff @(posedge sys_clk) begin
    if (in_rst) begin
      st_q   <= ST_INIT;
      init_q <= 5'd0;
      idx_q  <= 5'd0;
    end else begin
      unique case (st_q)
        ST_INIT: begin
          init_q <= init_q + 5'd1;
          if (init_q == 5'(dil_pkg::INIT_CYCLES - 1))
            st_q <= (dtr_q && !rts_q) ? ST_LEN : ST_NORM;
        end
        ST_LEN: if (pop) begin
          idx_q <= 5'd0;
          st_q  <= (buf_q[rd_q] == 8'h00) ? ST_NORM : ST_DATA;
        end
        ST_DATA: if (pop) begin
          idx_q <= idx_q + 5'd1;
          if (idx_q + 5'd1 == len_q)
            st_q <= ST_NORM;
        end
        ST_NORM: st_q <= ST_NORM;
      endcase
    end
  end
  // String store, default preloaded, replaced in order
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      len_q <= 5'(dil_pkg::DEF_LEN);
      for (int i = 0; i < dil_pkg::MAX_LEN; i++)
        mem_q[i] <= dil_pkg::DEF_STR[8*(dil_pkg::MAX_LEN-1-i) +: 8];
    end else if (!in_rst && pop) begin
      if (st_q == ST_LEN)
        len_q <= (buf_q[rd_q] > 8'(dil_pkg::MAX_LEN)) ?
                 5'(dil_pkg::MAX_LEN) : buf_q[rd_q][4:0];
      else if (st_q == ST_DATA)
        mem_q[idx_q] <= buf_q[rd_q];
    end
  end
  // Link permitted only if every stored character below id_len is valid
  always_comb begin
    link_allowed = 1'b1;
    for (int i = 0; i < dil_pkg::MAX_LEN; i++)
      if (5'(i) < len_q && !dil_pkg::char_ok(mem_q[i]))
        link_allowed = 1'b0;
  end
  // Clear-to-send pacing
  always_comb begin
    if (st_q == ST_LEN || st_q == ST_DATA)
      lnk.cts_n = (cnt_q != 2'd0) || v1_q || v1_s1_q;
    else if (st_q == ST_NORM)
      lnk.cts_n = ir_busy;
    else
      lnk.cts_n = 1'b1;
  end
  assign prog_mode = (st_q == ST_LEN) || (st_q == ST_DATA);
  assign id_len    = len_q;
  // Registered read port of the string store
  always_ff @(posedge sys_clk) begin
    rd_data <= (rd_addr < 5'(dil_pkg::MAX_LEN)) ? mem_q[rd_addr] : 8'h00;
  end
endmodule : dil_device
`default_nettype wire

// file: verilog/dil_host.sv
/*
  Host end: resets the device with lines in programming state, then sends
  length and string bytes paced by clear-to-send.
  Assumes the link interface and a device on the same sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dil_host (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  dil_link_if.host        lnk,
  input  wire logic       start,
  input  wire logic [4:0] len,
  input  wire logic [7:0] char_data,
  output logic [4:0]      char_idx,
  output logic            busy,
  output logic            done
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_RST = 3'b001, H_WAIT = 3'b010,
    H_SEND = 3'b011, H_GAP = 3'b100, H_END = 3'b101
  } dil_hstate_t;
  dil_hstate_t st_q;
  logic [4:0]  cnt_q, n_q, pos_q;
  logic        cts_s1_q, cts_q;
  logic [7:0]  tx_q;
  logic        v_q;
  // Synchronise clear-to-send
  always_ff @(posedge sys_clk) begin
    cts_s1_q <= lnk.cts_n;
    cts_q    <= cts_s1_q;
  end
  // Programming sequence
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q  <= H_IDLE;
      cnt_q <= 5'd0;
      n_q   <= 5'd0;
      pos_q <= 5'd0;
      v_q   <= 1'b0;
      tx_q  <= 8'h00;
      done  <= 1'b0;
    end else begin
      v_q <= 1'b0;
      unique case (st_q)
        H_IDLE: if (start) begin
          n_q   <= (len > 5'(dil_pkg::MAX_LEN)) ?
                   5'(dil_pkg::MAX_LEN) : len;
          cnt_q <= 5'd0;
          done  <= 1'b0;
          st_q  <= H_RST;
        end
        H_RST: begin
          cnt_q <= cnt_q + 5'd1;
          if (cnt_q == 5'(dil_pkg::RST_HOLD - 1)) begin
            cnt_q <= 5'd0;
            pos_q <= 5'd0;
            st_q  <= H_WAIT;
          end
        end
        H_WAIT: if (!cts_q) begin
          v_q  <= 1'b1;
          tx_q <= (pos_q == 5'd0) ? {3'b000, n_q} :
                  (dil_pkg::char_ok(char_data) ? char_data : 8'h20);
          st_q <= H_GAP;
        end
        H_GAP: begin
          cnt_q <= cnt_q + 5'd1;
          if (cnt_q == 5'(dil_pkg::BYTE_GAP)) begin
            cnt_q <= 5'd0;
            pos_q <= pos_q + 5'd1;
            st_q  <= (pos_q == n_q) ? H_END : H_WAIT;
          end
        end
        H_END: begin
          done <= 1'b1;
          st_q <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
  // Line levels: program state only while resetting or sending
  assign lnk.rst_dev_n = (st_q != H_RST);
  assign lnk.dtr = (st_q == H_RST) || (st_q == H_WAIT) ||
                   (st_q == H_GAP);
  assign lnk.rts = !lnk.dtr;
  assign lnk.tx_valid = v_q;
  assign lnk.tx_data  = tx_q;
  assign char_idx = (pos_q == 5'd0) ? 5'd0 : pos_q - 5'd1;
  assign busy = (st_q != H_IDLE);
endmodule : dil_host
`default_nettype wire

// file: verilog/dil_link_if.sv
/*
  Link between host and device: handshake lines and a byte channel
  standing for the UART. Assumes one common clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface dil_link_if;
  logic       rst_dev_n;  // Device reset line, low holds reset
  logic       dtr;        // Data terminal ready
  logic       rts;        // Request to send
  logic       cts_n;      // Clear to send, low lets host send
  logic       tx_valid;   // Byte strobe from host
  logic [7:0] tx_data;    // Byte from host
  modport dev (input rst_dev_n, input dtr, input rts, output cts_n,
               input tx_valid, input tx_data);
  modport host (output rst_dev_n, output dtr, output rts, input cts_n,
                output tx_valid, output tx_data);
endinterface : dil_link_if
`default_nettype wire

// file: verilog/dil_pkg.sv
/*
  Shared constants for the identification string loader: string limits,
  character range, byte gap, reset hold and the start-up delay.
  Assumes both ends are compiled after this package.
*/
// Function
// - Device holds replaceable string, factory default preloaded
// - String length at most nineteen bytes
// - Host sends characters 20h to 7Ah only
// - Program mode when ready high, request low
// - Otherwise normal mode after reset
// - Host: reset, set lines, release, wait
// - Device drives clear-to-send low to pace bytes
// - Host sends only while clear-to-send low
// - First byte is length; count ends programming
// - Host drops ready line after last byte
// - Invalid stored character blocks link establishment
// - Host never leaves lines in program state
// - Normal mode holds clear-to-send high while busy
package dil_pkg;
  localparam int         MAX_LEN      = 19;
  localparam logic [7:0] CHAR_MIN     = 8'h20;
  localparam logic [7:0] CHAR_MAX     = 8'h7A;
  localparam int         DEF_LEN      = 12;
  localparam int         INIT_CYCLES  = 16;
  localparam int         BYTE_GAP     = 4;
  localparam int         RST_HOLD     = 8;
  // Factory default string, first character leftmost; value is arbitrary
  localparam logic [8*MAX_LEN-1:0] DEF_STR = {"Default Name", {7{8'h20}}};
  function automatic logic char_ok(input logic [7:0] c);
    char_ok = (c >= CHAR_MIN) && (c <= CHAR_MAX);
  endfunction : char_ok
endpackage : dil_pkg
